/* common/ipw_defs.svh */
// Purpose: Offsets, bit positions, reset values and counts for the
//          flash page writer.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Included by the design and the bench.
`ifndef IPW_DEFS_SVH
`define IPW_DEFS_SVH

// ==========================================================
// Register offsets
`define IPW_OFS_CTRL 12'h000
`define IPW_OFS_AUX 12'h004
`define IPW_OFS_ADDR_LOW 12'h008
`define IPW_OFS_ADDR_HIGH 12'h00C
`define IPW_OFS_DATA_LOW 12'h010
`define IPW_OFS_DATA_HIGH 12'h014
`define IPW_OFS_RDATA 12'h018
`define IPW_OFS_IRQ_STAT 12'h01C
`define IPW_OFS_IRQ_MASK 12'h020
`define IPW_OFS_KEY 12'h024

// ==========================================================
// Control bit positions
`define IPW_CTRL_EN 7
`define IPW_CTRL_ERASE 3
`define IPW_CTRL_WRITE 2
`define IPW_CTRL_RDEN 1
`define IPW_CTRL_READ 0
`define IPW_AUX_CLR 0

// ==========================================================
// Interrupt bits and values
`define IPW_IRQ_W 4
`define IPW_IRQ_WRITE 0
`define IPW_IRQ_ERASE 1
`define IPW_IRQ_READ 2
`define IPW_IRQ_CLR 3
`define IPW_KEY_VAL 32'h0000_00A5
`define IPW_RST_WORD 16'h0000

`endif

/* common/ipw_pkg.sv */
// Purpose: Types shared by the flash page writer.
// Assumes: Flash addresses fit in 15 bits.
// Notes:   Constants live in ipw_defs.svh.
package ipw_pkg;

  // ========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    IPW_IDLE,
    IPW_ERASE,
    IPW_WRITE,
    IPW_READ
  } ipw_state_t;

  typedef enum logic [1:0] {
    IPW_OP_ERASE,
    IPW_OP_PROG,
    IPW_OP_READ
  } ipw_op_t;

  // ========================================================
  // Command to the flash array macro
  typedef struct packed {
    logic valid;
    ipw_op_t op;
    logic [14:0] addr;
    logic [15:0] wdata;
  } ipw_fl_cmd_t;

endpackage

/* core/ipw_flash_page_writer.sv */
// Purpose: Self-programming sequencer for the flash program memory.
// Assumes: Flash macro on ref_clk answers each command with fl_done.
// Notes:   APB slave with zero wait states.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "ipw_defs.svh"

module ipw_flash_page_writer
  import ipw_pkg::*;
#(
  parameter int PAGE_WORDS = 32,
  parameter int ADDR_W = 13
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output ipw_fl_cmd_t fl_cmd,
  input wire logic fl_done,
  input wire logic [15:0] fl_rdata,
  output logic irq
);

  localparam int OFS_W = $clog2(PAGE_WORDS);
  localparam int PG_W = ADDR_W - OFS_W;
  localparam logic [OFS_W-1:0] LAST = '1;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // ========================================================
  // Bus decode
  logic setup;
  logic wr;
  logic hit_ctrl;
  logic hit_aux;
  logic hit_alo;
  logic hit_ahi;
  logic hit_dlo;
  logic hit_dhi;
  logic hit_rd;
  logic hit_ist;
  logic hit_imk;
  logic hit_key;
  logic mapped;

  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_aux = 1'b0;
    hit_alo = 1'b0;
    hit_ahi = 1'b0;
    hit_dlo = 1'b0;
    hit_dhi = 1'b0;
    hit_rd = 1'b0;
    hit_ist = 1'b0;
    hit_imk = 1'b0;
    hit_key = 1'b0;
    if (paddr == `IPW_OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr == `IPW_OFS_AUX) begin
      hit_aux = 1'b1;
    end else if (paddr == `IPW_OFS_ADDR_LOW) begin
      hit_alo = 1'b1;
    end else if (paddr == `IPW_OFS_ADDR_HIGH) begin
      hit_ahi = 1'b1;
    end else if (paddr == `IPW_OFS_DATA_LOW) begin
      hit_dlo = 1'b1;
    end else if (paddr == `IPW_OFS_DATA_HIGH) begin
      hit_dhi = 1'b1;
    end else if (paddr == `IPW_OFS_RDATA) begin
      hit_rd = 1'b1;
    end else if (paddr == `IPW_OFS_IRQ_STAT) begin
      hit_ist = 1'b1;
    end else if (paddr == `IPW_OFS_IRQ_MASK) begin
      hit_imk = 1'b1;
    end else if (paddr == `IPW_OFS_KEY) begin
      hit_key = 1'b1;
    end
  end

  assign mapped = hit_ctrl | hit_aux | hit_alo | hit_ahi | hit_dlo |
                  hit_dhi | hit_rd | hit_ist | hit_imk | hit_key;

  // ========================================================
  // State
  ipw_state_t state;
  logic en_flag;
  logic rd_en;
  logic clr_req;
  logic [ADDR_W-1:0] faddr;
  logic [7:0] data_lo;
  logic [7:0] data_hi;
  logic [15:0] rd_word;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [OFS_W-1:0] widx;
  logic [`IPW_IRQ_W-1:0] irq_stat;
  logic [`IPW_IRQ_W-1:0] irq_mask;
  logic [`IPW_IRQ_W-1:0] ev;
  logic busy;
  logic load;
  logic write_done;
  logic [PG_W-1:0] page;

  assign busy = (state != IPW_IDLE);
  assign page = faddr[ADDR_W-1:OFS_W];
  // Loads need the enabled flag and an idle sequencer
  assign load = wr & hit_dhi & en_flag & ~busy;
  assign write_done = (state == IPW_WRITE) & fl_done & (widx == LAST);

  // ========================================================
  // Enable flag: key write opens, clearing the bit closes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_flag <= 1'b0;
    end else if (wr & hit_key) begin
      en_flag <= (pwdata == `IPW_KEY_VAL);
    end else if (wr & hit_ctrl & ~pwdata[`IPW_CTRL_EN]) begin
      en_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_en <= 1'b0;
    end else if (wr & hit_ctrl) begin
      rd_en <= pwdata[`IPW_CTRL_RDEN];
    end
  end

  // ========================================================
  // Sequencer; a start while busy is ignored
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= IPW_IDLE;
      widx <= '0;
    end else begin
      case (state)
        IPW_IDLE: begin
          widx <= '0;
          if (wr & hit_ctrl) begin
            if (pwdata[`IPW_CTRL_ERASE] & en_flag) begin
              state <= IPW_ERASE;
            end else if (pwdata[`IPW_CTRL_WRITE] & en_flag) begin
              state <= IPW_WRITE;
            end else if (pwdata[`IPW_CTRL_READ] &
                         pwdata[`IPW_CTRL_RDEN]) begin
              state <= IPW_READ;
            end
          end
        end
        IPW_ERASE: begin
          if (fl_done) begin
            state <= IPW_IDLE;
          end
        end
        IPW_WRITE: begin
          // Whole page goes out, one word per flash answer
          if (fl_done) begin
            widx <= widx + 1'b1;
            if (widx == LAST) begin
              state <= IPW_IDLE;
            end
          end
        end
        IPW_READ: begin
          if (fl_done) begin
            state <= IPW_IDLE;
          end
        end
        default: begin
          state <= IPW_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    fl_cmd = '0;
    fl_cmd.valid = busy;
    fl_cmd.op = IPW_OP_READ;
    fl_cmd.addr = 15'(faddr);
    if (state == IPW_ERASE) begin
      fl_cmd.op = IPW_OP_ERASE;
      fl_cmd.addr = 15'({page, {OFS_W{1'b0}}});
    end else if (state == IPW_WRITE) begin
      fl_cmd.op = IPW_OP_PROG;
      fl_cmd.addr = 15'({page, widx});
      fl_cmd.wdata = buf_mem[widx];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_word <= `IPW_RST_WORD;
    end else if (state == IPW_READ && fl_done) begin
      rd_word <= fl_rdata;
    end
  end

  // ========================================================
  // Address and data registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      faddr <= '0;
    end else if (load) begin
      if (faddr[OFS_W-1:0] != LAST) begin
        faddr <= faddr + 1'b1;
      end
    end else if (wr & hit_alo & ~busy) begin
      faddr[7:0] <= pwdata[7:0];
    end else if (wr & hit_ahi & ~busy) begin
      faddr[ADDR_W-1:8] <= pwdata[ADDR_W-9:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_lo <= '0;
      data_hi <= '0;
    end else begin
      if (wr & hit_dlo) begin
        data_lo <= pwdata[7:0];
      end
      if (wr & hit_dhi) begin
        data_hi <= pwdata[7:0];
      end
    end
  end

  // ========================================================
  // Write buffer; cleared in one cycle, so the request is short
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_req <= 1'b0;
    end else if (clr_req) begin
      clr_req <= 1'b0;
    end else if (wr & hit_aux & ~busy) begin
      clr_req <= pwdata[`IPW_AUX_CLR];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        buf_mem[i] <= `IPW_RST_WORD;
      end
    end else if (clr_req | write_done) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        buf_mem[i] <= `IPW_RST_WORD;
      end
    end else if (load) begin
      buf_mem[faddr[OFS_W-1:0]] <= {pwdata[7:0], data_lo};
    end
  end

  // ========================================================
  // Interrupts: set beats a write-one clear
  assign ev[`IPW_IRQ_WRITE] = write_done;
  assign ev[`IPW_IRQ_ERASE] = (state == IPW_ERASE) & fl_done;
  assign ev[`IPW_IRQ_READ] = (state == IPW_READ) & fl_done;
  assign ev[`IPW_IRQ_CLR] = clr_req;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat <= '0;
    end else if (wr & hit_ist) begin
      irq_stat <= (irq_stat & ~pwdata[`IPW_IRQ_W-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= '0;
    end else if (wr & hit_imk) begin
      irq_mask <= pwdata[`IPW_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ========================================================
  // Read data captured in setup phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= '0;
      pslverr <= ~mapped;
      if (hit_ctrl) begin
        prdata[`IPW_CTRL_EN] <= en_flag;
        prdata[`IPW_CTRL_ERASE] <= (state == IPW_ERASE);
        prdata[`IPW_CTRL_WRITE] <= (state == IPW_WRITE);
        prdata[`IPW_CTRL_RDEN] <= rd_en;
        prdata[`IPW_CTRL_READ] <= (state == IPW_READ);
      end else if (hit_aux) begin
        prdata[`IPW_AUX_CLR] <= clr_req;
      end else if (hit_alo) begin
        prdata[7:0] <= faddr[7:0];
      end else if (hit_ahi) begin
        prdata[ADDR_W-9:0] <= faddr[ADDR_W-1:8];
      end else if (hit_dlo) begin
        prdata[7:0] <= data_lo;
      end else if (hit_dhi) begin
        prdata[7:0] <= data_hi;
      end else if (hit_rd) begin
        prdata[15:0] <= rd_word;
      end else if (hit_ist) begin
        prdata[`IPW_IRQ_W-1:0] <= irq_stat;
      end else if (hit_imk) begin
        prdata[`IPW_IRQ_W-1:0] <= irq_mask;
      end
    end
  end

  // ========================================================
  // Checks
  page_erase_a: assert property (state == IPW_ERASE |->
    fl_cmd.addr[OFS_W-1:0] == '0)
    else $error("erase not page aligned");

  write_busy_a: assert property (state == IPW_IDLE && wr &&
    hit_ctrl && en_flag && pwdata[`IPW_CTRL_WRITE] &&
    !pwdata[`IPW_CTRL_ERASE] |=> state == IPW_WRITE)
    else $error("write start not taken");

  read_gate_a: assert property (wr && hit_ctrl && !busy &&
    !pwdata[`IPW_CTRL_RDEN] |=> state != IPW_READ)
    else $error("read started without enable");

  addr_inc_a: assert property (load &&
    faddr[OFS_W-1:0] != LAST |=> faddr == $past(faddr) + 1)
    else $error("address not incremented");

  addr_park_a: assert property (load &&
    faddr[OFS_W-1:0] == LAST |=> $stable(faddr))
    else $error("address passed page end");

  clr_pulse_a: assert property (clr_req |=>
    !clr_req && buf_mem[0] == '0)
    else $error("clear request stuck");

  post_write_a: assert property (write_done |=>
    buf_mem[PAGE_WORDS-1] == '0 && !busy)
    else $error("buffer not cleared after write");

  busy_hold_a: assert property (busy && wr &&
    (hit_alo || hit_ahi || hit_dhi) |=> $stable(faddr))
    else $error("address changed while busy");

  load_gate_a: assert property (wr && hit_dhi && !en_flag |=>
    $stable(faddr))
    else $error("load taken without enable");

  lo_only_a: assert property (wr && hit_dlo |=>
    $stable(faddr) && data_lo == $past(pwdata[7:0]))
    else $error("low byte write moved address");

endmodule

/* tb/ipw_flash_page_writer_tb_top.sv */
// Purpose: Self-checking bench for the flash page writer.
// Assumes: PAGE_WORDS 32, ADDR_W 13; bench answers flash commands.
// Notes:   APB master tasks plus a flash macro responder.
`timescale 1ns/1ns
`include "ipw_defs.svh"

module ipw_flash_page_writer_tb_top import ipw_pkg::*;;
  localparam logic [11:0] o_ctrl = `IPW_OFS_CTRL;
  localparam logic [11:0] o_aux = `IPW_OFS_AUX;
  localparam logic [11:0] o_al = `IPW_OFS_ADDR_LOW;
  localparam logic [11:0] o_ah = `IPW_OFS_ADDR_HIGH;
  localparam logic [11:0] o_dl = `IPW_OFS_DATA_LOW;
  localparam logic [11:0] o_dh = `IPW_OFS_DATA_HIGH;
  localparam logic [11:0] o_st = `IPW_OFS_IRQ_STAT;
  localparam logic [11:0] o_mk = `IPW_OFS_IRQ_MASK;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic fl_done, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fl_rdata;
  logic [15:0] wexp [0:31];
  ipw_fl_cmd_t fl_cmd;
  int err_total, samples_checked, cycles, i;

  ipw_flash_page_writer #(.PAGE_WORDS(32), .ADDR_W(13))
    ipw_flash_page_writer_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fl_cmd(fl_cmd),
    .fl_done(fl_done), .fl_rdata(fl_rdata), .irq(irq));

  // ==========================================================
  // Clock, reset and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole run needs well under 2000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", pready, 1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [31:0] exp);
    apb(1'b0, a, 0);
    chk(nm, rd, exp);
  endtask

  task automatic load(input logic [7:0] lo, input logic [7:0] hi);
    wr(o_dl, lo);
    wr(o_dh, hi);
  endtask

  // Acts as the flash macro: checks each command, then pulses done
  task automatic serve(input ipw_op_t op, input logic [14:0] a0,
                       input int n, input logic [15:0] d);
    int k;
    int w;
    for (k = 0; k < n; k++) begin
      w = 0;
      do begin
        @(posedge ref_clk);
        w++;
      end while (fl_cmd.valid !== 1'b1 && w < 64);
      chk("fl_valid", fl_cmd.valid, 1);
      chk("fl_op", fl_cmd.op, op);
      chk("fl_addr", fl_cmd.addr, a0 + k);
      if (op == IPW_OP_PROG) begin
        chk("fl_wdata", fl_cmd.wdata, wexp[k]);
      end
      fl_rdata <= d;
      fl_done <= 1'b1;
      @(posedge ref_clk);
      fl_done <= 1'b0;
    end
  endtask

  // Software erases the page before every write to it
  task automatic erase(input logic [14:0] a);
    wr(o_ctrl, 8'h88);
    serve(IPW_OP_ERASE, a, 1, 16'h0000);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fl_done = 1'b0;
    fl_rdata = 16'h0000;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    chk("irq", irq, 0);
    chk("fl_valid", fl_cmd.valid, 0);
    rc("ctrl", o_ctrl, 0);
    apb(1'b0, 12'h030, 0);
    chk("slverr", se, 1);
    // Loads before enabling must not move the address
    wr(o_ah, 8'h01);
    wr(o_al, 8'h40);
    load(8'h11, 8'h22);
    rc("addr_low", o_al, 8'h40);
    wr(`IPW_OFS_KEY, `IPW_KEY_VAL);
    rc("ctrl", o_ctrl, 8'h80);
    wr(o_aux, 1);
    rc("aux", o_aux, 0);
    rc("irq_stat", o_st, 8'h08);
    wr(o_st, 8'h0F);
    wr(o_dl, 8'h55);
    rc("addr_low", o_al, 8'h40);
    // Fill past the page end; last slot keeps being overwritten
    for (i = 0; i < 34; i++) begin
      load(i[7:0], 8'hA0 + i[7:0]);
      wexp[(i < 31) ? i : 31] = {8'hA0 + i[7:0], i[7:0]};
      rc("addr_low", o_al, 8'h40 + ((i < 31) ? i + 1 : 31));
    end
    rc("addr_high", o_ah, 8'h01);
    // Parked address: name the page again before erase and write
    wr(o_al, 8'h40);
    erase(15'h0140);
    wr(o_mk, 0);
    wr(o_ctrl, 8'h84);
    rc("ctrl_busy", o_ctrl, 8'h84);
    wr(o_al, 8'h00);
    wr(o_ctrl, 8'h88);
    load(8'h01, 8'h02);
    rc("addr_busy", o_al, 8'h40);
    serve(IPW_OP_PROG, 15'h0140, 32, 0);
    rc("ctrl_done", o_ctrl, 8'h80);
    rc("irq_stat", o_st, 8'h03);
    chk("irq_masked", irq, 0);
    wr(o_mk, 1);
    @(posedge ref_clk);
    chk("irq_set", irq, 1);
    wr(o_st, 1);
    @(posedge ref_clk);
    chk("irq_clr", irq, 0);
    // Buffer must be empty after a write and after a manual clear
    for (i = 0; i < 32; i++) begin
      wexp[i] = 16'h0000;
    end
    wr(o_al, 8'h40);
    erase(15'h0140);
    wr(o_ctrl, 8'h84);
    serve(IPW_OP_PROG, 15'h0140, 32, 0);
    wr(o_al, 8'h40);
    load(8'h33, 8'h44);
    wr(o_aux, 1);
    wr(o_al, 8'h40);
    erase(15'h0140);
    wr(o_ctrl, 8'h84);
    serve(IPW_OP_PROG, 15'h0140, 32, 0);
    // Erase ignores the word offset bits
    wr(o_ah, 8'h0A);
    wr(o_al, 8'h6B);
    wr(o_ctrl, 8'h88);
    serve(IPW_OP_ERASE, 15'h0A60, 1, 0);
    rc("ctrl_erase", o_ctrl, 8'h80);
    wr(o_ctrl, 8'h81);
    repeat (3) @(posedge ref_clk);
    chk("read_no_en", fl_cmd.valid, 0);
    wr(o_ctrl, 8'h83);
    rc("ctrl_read", o_ctrl, 8'h83);
    serve(IPW_OP_READ, 15'h0A6B, 1, 16'hBEEF);
    rc("rdata", `IPW_OFS_RDATA, 16'hBEEF);
    rc("ctrl_rdone", o_ctrl, 8'h82);
    rc("irq_end", o_st, 8'h0F);
    print_verdict();
  end
endmodule
